// ### common/rsf_pkg.sv
package rsf_pkg;

   // ----------------------------------------
   // mode encodings
   // ----------------------------------------
   localparam logic [1:0] RSF_MODE_PRESET    = 2'h0;
   localparam logic [1:0] RSF_MODE_STORE     = 2'h1;
   localparam logic [1:0] RSF_MODE_NOSTORE   = 2'h2;
   localparam logic [1:0] RSF_MODE_CLR_ON_STOP = 2'h3;

   localparam logic [1:0] RSF_OPM_EXT_PANEL  = 2'h3;
   localparam logic       RSF_COMP_ON        = 1'h1;

   // ----------------------------------------
   // widths and timing
   // ----------------------------------------
   localparam int RSF_FW          = 16;
   localparam int RSF_TW          = 16;
   localparam int RSF_CLK_MHZ     = 200;
   localparam int RSF_SAVE_PERIOD_S = 60;
   localparam longint RSF_SAVE_CYCLES = longint'(RSF_SAVE_PERIOD_S) * 1000000 * RSF_CLK_MHZ;
   localparam int RSF_STEP_DEF    = 1;

   localparam logic [RSF_FW-1:0] RSF_FREQ_RST = 16'h0000;

   // ----------------------------------------
   // grouped carriers
   // ----------------------------------------
   typedef struct packed {
      logic increase_input;
      logic decrease_input;
      logic clear_input;
   } rsf_contacts_t;

   typedef struct packed {
      logic forward_run_cmd;
      logic reverse_run_cmd;
   } rsf_run_t;

   typedef struct packed {
      logic [RSF_FW-1:0] ext_ref;
      logic [RSF_FW-1:0] current_in;
      logic [RSF_FW-1:0] aux_volt;
      logic [RSF_FW-1:0] panel_freq;
   } rsf_refs_t;

   typedef struct packed {
      logic [RSF_TW-1:0] primary_accel_time;
      logic [RSF_TW-1:0] primary_decel_time;
      logic [RSF_TW-1:0] second_ramp_time;
      logic [RSF_TW-1:0] second_decel_time;
   } rsf_times_t;

   typedef enum logic [2:0] {
      RSF_SPD_NONE = 3'b001,
      RSF_SPD_SEL  = 3'b010,
      RSF_SPD_REM  = 3'b100
   } rsf_src_t;

endpackage

// ### design/rsf_remote_speed.sv
// Behaviour
// - remote mode: 0 preset, 1 store, 2/3 no store
// - remote modes: high=increase, mid=decrease, low=clear
// - external: remote plus external plus current input
// - panel: remote plus panel running frequency
// - auxiliary input only when compensation selected
// - mode 1 saves setting, resumes after power
// - save setting when run command falls
// - idle minute: compare and write if changed
// - ramp select off: longer of second/primary during increase/decrease, else primary
// - ramp select on: second times always
// - increase/decrease work without run command
// - jog or closed loop disables remote
// - network operation also supports remote
// - mode 0: lower-order speed input wins
`timescale 1ns/1ps
`default_nettype none

module rsf_remote_speed
   import rsf_pkg::*;
#(
   parameter longint SAVE_CYCLES = RSF_SAVE_CYCLES,
   parameter logic [RSF_FW-1:0] STEP = RSF_FW'(RSF_STEP_DEF)
)
(
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire rsf_contacts_t     contacts,
   input  wire rsf_run_t          run,
   input  wire logic              ramp_select_input,
   input  wire logic [1:0]        remote_mode_setting,
   input  wire logic              compensation_selection,
   input  wire logic [1:0]        operation_mode_setting,
   input  wire logic              panel_unit,
   input  wire logic              network_op,
   input  wire logic              jog_active,
   input  wire logic              closed_loop_control,
   input  wire rsf_refs_t         refs,
   input  wire rsf_times_t        times,
   input  wire logic [RSF_FW-1:0] max_freq,
   input  wire logic [RSF_FW-1:0] preset_high,
   input  wire logic [RSF_FW-1:0] preset_mid,
   input  wire logic [RSF_FW-1:0] preset_low,
   input  wire logic [RSF_FW-1:0] nv_value,
   input  wire logic              nv_valid,
   output logic [RSF_FW-1:0]      remote_freq_q,
   output logic [RSF_FW-1:0]      out_freq_q,
   output logic [RSF_TW-1:0]      accel_time_q,
   output logic [RSF_TW-1:0]      decel_time_q,
   output logic                   nv_write_q,
   output logic [RSF_FW-1:0]      nv_wdata_q,
   output logic                   remote_active_q
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [RSF_FW-1:0] sat_add(input logic [RSF_FW-1:0] a, input logic [RSF_FW-1:0] b);
      logic [RSF_FW:0] s;
      s = {1'b0, a} + {1'b0, b};
      sat_add = s[RSF_FW] ? {RSF_FW{1'b1}} : s[RSF_FW-1:0];
   endfunction

   function automatic logic [RSF_TW-1:0] tmax(input logic [RSF_TW-1:0] a, input logic [RSF_TW-1:0] b);
      tmax = (a > b) ? a : b;
   endfunction

   // ----------------------------------------
   // decode
   // ----------------------------------------
   logic remote_en;
   logic run_on;
   logic inc;
   logic dec;
   logic clr;
   logic store_en;

   // network mode carries the same contacts, so it needs no separate path
   assign remote_en = (remote_mode_setting != RSF_MODE_PRESET)
                      && !jog_active && !closed_loop_control;
   assign run_on   = run.forward_run_cmd | run.reverse_run_cmd;
   assign inc      = remote_en & contacts.increase_input;
   assign dec      = remote_en & contacts.decrease_input;
   assign clr      = remote_en & contacts.clear_input;
   assign store_en = (remote_mode_setting == RSF_MODE_STORE);

   logic run_q;
   logic run_fall;
   assign run_fall = run_q & ~run_on;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         run_q <= 1'b0;
      else
         run_q <= run_on;
   end

   // ----------------------------------------
   // power-up restore
   // ----------------------------------------
   // nv value is caught after reset release, never under the reset itself
   logic restored_q;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         restored_q <= 1'b0;
      else if (nv_valid)
         restored_q <= 1'b1;
   end

   // ----------------------------------------
   // remote setting
   // ----------------------------------------
   logic [RSF_FW-1:0] rem_d;

   always_comb
   begin
      rem_d = remote_freq_q;
      if (!restored_q && nv_valid && store_en)
         rem_d = (nv_value > max_freq) ? max_freq : nv_value;
      else if (clr)
         rem_d = RSF_FREQ_RST;
      else if (remote_en && remote_mode_setting == RSF_MODE_CLR_ON_STOP && run_fall)
         rem_d = RSF_FREQ_RST;
      else if (inc && !dec)
         rem_d = (remote_freq_q >= max_freq - STEP || max_freq < STEP) ? max_freq
                 : remote_freq_q + STEP;
      else if (dec && !inc)
         rem_d = (remote_freq_q < STEP) ? RSF_FREQ_RST : remote_freq_q - STEP;
      if (rem_d > max_freq)
         rem_d = max_freq;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         remote_freq_q <= RSF_FREQ_RST;
      else
         remote_freq_q <= rem_d;
   end

   // ----------------------------------------
   // storage
   // ----------------------------------------
   // minute timer restarts on any increase/decrease activity
   logic [63:0]       idle_cnt_q;
   logic [RSF_FW-1:0] saved_q;
   logic              minute_tick;

   assign minute_tick = (idle_cnt_q == 64'(SAVE_CYCLES - 1));

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         idle_cnt_q <= '0;
      else if (inc || dec || minute_tick)
         idle_cnt_q <= '0;
      else
         idle_cnt_q <= idle_cnt_q + 64'h1;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         nv_write_q <= 1'b0;
         nv_wdata_q <= RSF_FREQ_RST;
         saved_q    <= RSF_FREQ_RST;
      end
      else
      begin
         nv_write_q <= 1'b0;
         if (!restored_q && nv_valid)
            saved_q <= nv_value;
         else if (store_en && remote_en && run_fall)
         begin
            nv_write_q <= 1'b1;
            nv_wdata_q <= remote_freq_q;
            saved_q    <= remote_freq_q;
         end
         else if (store_en && remote_en && minute_tick && remote_freq_q != saved_q)
         begin
            nv_write_q <= 1'b1;
            nv_wdata_q <= remote_freq_q;
            saved_q    <= remote_freq_q;
         end
      end
   end

   // ----------------------------------------
   // output frequency
   // ----------------------------------------
   logic [RSF_FW-1:0] base;
   logic [RSF_FW-1:0] preset_sel;
   logic [RSF_FW-1:0] freq_d;
   rsf_src_t          src;

   always_comb
   begin
      preset_sel = RSF_FREQ_RST;
      src        = RSF_SPD_NONE;
      if (remote_en)
         src = RSF_SPD_REM;
      else if (contacts.clear_input)
      begin
         preset_sel = preset_low;
         src        = RSF_SPD_SEL;
      end
      else if (contacts.decrease_input)
      begin
         preset_sel = preset_mid;
         src        = RSF_SPD_SEL;
      end
      else if (contacts.increase_input)
      begin
         preset_sel = preset_high;
         src        = RSF_SPD_SEL;
      end
   end

   always_comb
   begin
      if (panel_unit)
         base = refs.panel_freq;
      else if (operation_mode_setting == RSF_OPM_EXT_PANEL)
         base = sat_add(refs.panel_freq, refs.current_in);
      else
         base = sat_add(refs.ext_ref, refs.current_in);
      // aux voltage only joins when compensation is chosen
      if (!panel_unit && compensation_selection == RSF_COMP_ON)
         base = sat_add(base, refs.aux_volt);
      unique case (src)
         RSF_SPD_REM: freq_d = sat_add(remote_freq_q, base);
         RSF_SPD_SEL: freq_d = preset_sel;
         RSF_SPD_NONE: freq_d = base;
      endcase
      if (freq_d > max_freq)
         freq_d = max_freq;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         out_freq_q      <= RSF_FREQ_RST;
         remote_active_q <= 1'b0;
      end
      else
      begin
         out_freq_q      <= freq_d;
         remote_active_q <= remote_en;
      end
   end

   // ----------------------------------------
   // ramp times
   // ----------------------------------------
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         accel_time_q <= '0;
         decel_time_q <= '0;
      end
      else if (ramp_select_input)
      begin
         accel_time_q <= times.second_ramp_time;
         decel_time_q <= times.second_decel_time;
      end
      else if (inc || dec)
      begin
         accel_time_q <= tmax(times.second_ramp_time, times.primary_accel_time);
         decel_time_q <= tmax(times.second_decel_time, times.primary_decel_time);
      end
      else
      begin
         accel_time_q <= times.primary_accel_time;
         decel_time_q <= times.primary_decel_time;
      end
   end

endmodule

`default_nettype wire

// ### sim/rsf_remote_speed_checker.sv
`timescale 1ns/1ps
`default_nettype none
module rsf_remote_speed_checker
   import rsf_pkg::*;
#(
   parameter logic [RSF_FW-1:0] STEP = RSF_FW'(RSF_STEP_DEF)
)
(
   input wire logic              ref_clk,
   input wire logic              rst,
   input wire rsf_contacts_t     contacts,
   input wire rsf_run_t          run,
   input wire logic [1:0]        remote_mode_setting,
   input wire logic              jog_active,
   input wire logic              closed_loop_control,
   input wire logic [RSF_FW-1:0] max_freq,
   input wire logic [RSF_FW-1:0] remote_freq_q,
   input wire logic              nv_write_q,
   input wire logic [RSF_FW-1:0] nv_wdata_q
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic rem;
   logic fall;
   assign rem = remote_mode_setting != 2'h0 && !jog_active && !closed_loop_control;
   // ----------------------------------------
   // remote setting relations
   // ----------------------------------------
   always_ff @(posedge ref_clk or posedge rst)
      if (rst)
         fall <= 1'b0;
      else
         fall <= run != 2'h0;
   inc_step_a: assert property (
      rem && remote_mode_setting == 2'h2 && contacts == 3'h4 && remote_freq_q + STEP <= max_freq
      |=> remote_freq_q == $past(remote_freq_q) + STEP) else $error("increase did not step");
   dec_step_a: assert property (
      rem && remote_mode_setting == 2'h2 && contacts == 3'h2 && remote_freq_q >= STEP
      |=> remote_freq_q == $past(remote_freq_q) - STEP) else $error("decrease did not step");
   both_hold_a: assert property (rem && remote_mode_setting == 2'h2 && contacts == 3'h6
      |=> $stable(remote_freq_q)) else $error("both contacts moved value");
   clear_zero_a: assert property (rem && contacts.clear_input |=> remote_freq_q == 16'h0)
      else $error("clear did not zero");
   clamp_max_a: assert property (remote_freq_q <= max_freq) else $error("value above max");
   stop_clear_a: assert property (
      rem && remote_mode_setting == 2'h3 && fall && run == 2'h0 |=> remote_freq_q == 16'h0)
      else $error("stop did not clear");
   stop_save_a: assert property (
      rem && remote_mode_setting == 2'h1 && fall && run == 2'h0
      |=> nv_write_q && nv_wdata_q == $past(remote_freq_q)) else $error("stop did not save");
   no_store_a: assert property (remote_mode_setting[1] |=> !nv_write_q)
      else $error("write in no-store mode");
   cover property (nv_write_q);
   cover property (rem && contacts == 3'h6);
   cover property (remote_freq_q == max_freq);
endmodule
bind rsf_remote_speed rsf_remote_speed_checker #(.STEP(STEP)) u_chk (.ref_clk(ref_clk), .rst(rst),
   .contacts(contacts), .run(run), .remote_mode_setting(remote_mode_setting), .jog_active(jog_active),
   .closed_loop_control(closed_loop_control), .max_freq(max_freq), .remote_freq_q(remote_freq_q),
   .nv_write_q(nv_write_q), .nv_wdata_q(nv_wdata_q));
`default_nettype wire

// ### sim/rsf_contact_model.sv
`timescale 1ns/1ps
`default_nettype none
module rsf_contact_model
   import rsf_pkg::*;
(
   input  wire logic          ref_clk,
   input  wire logic          rst,
   input  wire rsf_contacts_t want_c,
   input  wire rsf_run_t      want_r,
   output var rsf_contacts_t  contacts,
   output var rsf_run_t       run
);
   // contacts follow the controller one clock late, like a relay
   always_ff @(posedge ref_clk or posedge rst)
      if (rst)
      begin
         contacts <= '0;
         run      <= '0;
      end
      else
      begin
         contacts <= want_c;
         run      <= want_r;
      end
endmodule
`default_nettype wire

// ### sim/rsf_remote_speed_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rsf_remote_speed_tb_top
   import rsf_pkg::*;
();
   typedef struct packed {
      logic [1:0]    m;
      rsf_contacts_t c;
      logic          pu;
      logic          comp;
      logic [1:0]    opm;
      logic [7:0]    n;
      logic [15:0]   r;
   } rsf_row_t;
   localparam int SAVE = 20;
   logic          ref_clk = 1'b0, rst = 1'b1, ramp_sel = 1'b0, comp = 1'b0, pu = 1'b0;
   logic          net = 1'b0, jog = 1'b0, cl = 1'b0, nv_ok = 1'b0, nvw, ract;
   logic [1:0]    mode = 2'h2, opm = 2'h0;
   logic [15:0]   remote, out, acc, dec, nvd, last_w = 16'h0;
   rsf_contacts_t want_c = '0, contacts;
   rsf_run_t      want_r = '0, run;
   int            err_count = 0, n_compared = 0, n_w = 0, k;
   rsf_refs_t     refs = {16'h0001, 16'h0002, 16'h0004, 16'h0003};
   rsf_times_t    times = {16'h0010, 16'h0030, 16'h0020, 16'h0028};
   rsf_row_t      rows [8] = '{'{2'h2, 3'h4, 1'b0, 1'b0, 2'h0, 8'h05, 16'h5},
      '{2'h2, 3'h2, 1'b1, 1'b0, 2'h0, 8'h02, 16'h3}, '{2'h2, 3'h6, 1'b0, 1'b0, 2'h3, 8'h04, 16'h3},
      '{2'h2, 3'h4, 1'b0, 1'b1, 2'h0, 8'h14, 16'h10}, '{2'h2, 3'h1, 1'b0, 1'b0, 2'h0, 8'h01, 16'h0},
      '{2'h2, 3'h2, 1'b0, 1'b0, 2'h0, 8'h03, 16'h0}, '{2'h3, 3'h4, 1'b0, 1'b0, 2'h0, 8'h04, 16'h4},
      '{2'h1, 3'h4, 1'b1, 1'b0, 2'h0, 8'h02, 16'h6}};
   rsf_remote_speed #(.SAVE_CYCLES(SAVE)) DUT (.ref_clk(ref_clk), .rst(rst), .contacts(contacts), .run(run),
      .ramp_select_input(ramp_sel), .remote_mode_setting(mode), .compensation_selection(comp),
      .operation_mode_setting(opm), .panel_unit(pu), .network_op(net), .jog_active(jog),
      .closed_loop_control(cl), .refs(refs), .times(times), .max_freq(16'h0010), .preset_high(16'h000a),
      .preset_mid(16'h000b), .preset_low(16'h000c), .nv_value(16'h0007), .nv_valid(nv_ok),
      .remote_freq_q(remote), .out_freq_q(out), .accel_time_q(acc), .decel_time_q(dec), .nv_write_q(nvw),
      .nv_wdata_q(nvd), .remote_active_q(ract));
   rsf_contact_model u_sw (.ref_clk(ref_clk), .rst(rst), .want_c(want_c), .want_r(want_r),
      .contacts(contacts), .run(run));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
      if (nvw === 1'b1)
      begin
         n_w++;
         last_w = nvd;
      end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      @(negedge ref_clk);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic press(input rsf_contacts_t c, input rsf_run_t r, input int n);
      @(posedge ref_clk);
      want_c <= c;
      want_r <= r;
      repeat (n) @(posedge ref_clk);
      want_c <= '0;
      repeat (4) @(posedge ref_clk);
   endtask
   function automatic logic [15:0] exp_out(input logic [15:0] r);
      logic [15:0] s;
      s = pu ? r + refs.panel_freq
         : r + (opm == 2'h3 ? refs.panel_freq : refs.ext_ref) + refs.current_in + (comp ? refs.aux_volt : 16'h0);
      // output is capped at the maximum frequency
      return (s > 16'h0010) ? 16'h0010 : s;
   endfunction
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      #100000;
      err_count++;
      final_report();
   end
   initial
   begin
      repeat (3) @(posedge ref_clk);
      chk({remote, nvw}, 32'h0);
      @(posedge ref_clk);
      rst <= 1'b0;
      foreach (rows[i])
      begin
         @(posedge ref_clk);
         mode <= rows[i].m;
         pu <= rows[i].pu;
         comp <= rows[i].comp;
         opm <= rows[i].opm;
         net <= i[0];
         refs.ext_ref <= 16'h0001 + 16'(i);
         press(rows[i].c, 2'h0, rows[i].n);
         chk({remote, 15'h0, ract}, {rows[i].r, 16'h1});
         chk(out, exp_out(rows[i].r));
         $display("row %0d done", i);
      end
      @(posedge ref_clk);
      mode <= 2'h3;
      press(3'h4, 2'h2, 2);
      press(3'h0, 2'h0, 1);
      chk(remote, 16'h0);
      @(posedge ref_clk);
      mode <= 2'h1;
      press(3'h4, 2'h1, 3);
      k = n_w;
      press(3'h0, 2'h0, 1);
      chk({n_w - k, last_w}, 32'h0001_0003);
      press(3'h4, 2'h0, 2);
      k = n_w;
      repeat (3 * SAVE) @(posedge ref_clk);
      chk({n_w - k, last_w}, 32'h0001_0005);
      press(3'h1, 2'h0, 1);
      repeat (3 * SAVE) @(posedge ref_clk);
      chk({n_w - k, last_w}, 32'h0002_0000);
      $display("save tests done");
      @(posedge ref_clk);
      nv_ok <= 1'b1;
      rst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk(remote, 16'h7);
      @(posedge ref_clk);
      want_c <= 3'h2;
      repeat (3) @(posedge ref_clk);
      ramp_sel <= 1'b1;
      chk({acc, dec}, 32'h0020_0030);
      repeat (2) @(posedge ref_clk);
      chk({acc, dec}, 32'h0020_0028);
      @(posedge ref_clk);
      want_c <= 3'h0;
      ramp_sel <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk({acc, dec}, 32'h0010_0030);
      press(3'h1, 2'h0, 1);
      for (int j = 0; j < 3; j++)
      begin
         @(posedge ref_clk);
         mode <= (j == 2) ? 2'h0 : 2'h2;
         jog <= (j == 0);
         cl <= (j == 1);
         press(3'h4, 2'h0, 3);
         chk({remote, ract}, 32'h0);
      end
      @(posedge ref_clk);
      want_c <= 3'h6;
      repeat (4) @(posedge ref_clk);
      chk(out, 16'h000b);
      @(posedge ref_clk);
      want_c <= 3'h0;
      $display("ramp and disable tests done");
      final_report();
   end
endmodule
`default_nettype wire
